// >>> aisc_defines.vh
// Constants of the analog input scaling block: dictionary entries,
// reset values and the fixed figures of the physical scales.
// Assumes inclusion by bare name from the design files of this block.
`ifndef AISC_DEFINES_VH
`define AISC_DEFINES_VH

// ============================================================
// Dictionary indices of the three tables.
`define AISC_IDX_SCALED     16'h3320
`define AISC_IDX_OFFSET     16'h3321
`define AISC_IDX_DIVISOR    16'h3322

// ============================================================
// Subindices shared by all three tables.
`define AISC_SUB_COUNT      8'h00
`define AISC_SUB_CH1        8'h01
`define AISC_SUB_CH2        8'h02

// ============================================================
// Reset and fixed values.
`define AISC_CHAN_COUNT     8'h02
`define AISC_SCALED_RST     32'h00000000
`define AISC_OFFSET_RST     32'h00000000
`define AISC_DIVISOR_RST    32'h00000001
`define AISC_DIVISOR_BAD    32'h00000000

// ============================================================
// Physical scales: full span of 1024 digits is two to the tenth.
`define AISC_SPAN_SHIFT     10
`define AISC_FULL_MV        17'h02710
`define AISC_FULL_UA        17'h04e20

`endif

// >>> aisc_div.v
// Sequential signed divider, one quotient bit per clock.
// Assumes a non-zero divisor and a start only while not busy.
`timescale 1ns/1ns
`default_nettype none

module aisc_div #(
    parameter W = 32                      // Operand width.
) (
    input  wire         core_clk,         // Block clock.
    input  wire         rst,              // Synchronous reset, high.
    input  wire         start,            // Take operands this cycle.
    input  wire [W-1:0] dividend,         // Signed dividend.
    input  wire [W-1:0] divisor,          // Signed divisor, not zero.
    output wire         busy,             // Division in progress.
    output wire         done,             // Quotient valid, one cycle.
    output wire [W-1:0] quotient          // Signed quotient.
);

    localparam CW = $clog2(W + 1);
    localparam [CW-1:0] STEPS = W;
    localparam [CW-1:0] ONE   = 1;

    reg [W-1:0]  quo_q;
    reg [W-1:0]  rem_q;
    reg [W-1:0]  den_q;
    reg [W-1:0]  res_q;
    reg [CW-1:0] cnt_q;
    reg          neg_q;
    reg          busy_q;
    reg          done_q;

    // Trial subtraction of the divisor from the shifted remainder.
    wire [W:0]   trial = {rem_q, quo_q[W-1]} - {1'b0, den_q};
    wire         fits  = ~trial[W];
    wire [W-1:0] qnext = {quo_q[W-2:0], fits};

    // Magnitudes are divided and the sign applied last, which makes
    // the quotient truncate toward zero.
    always @(posedge core_clk) begin
        if (rst) begin
            quo_q  <= {W{1'b0}};
            rem_q  <= {W{1'b0}};
            den_q  <= {W{1'b0}};
            res_q  <= {W{1'b0}};
            cnt_q  <= {CW{1'b0}};
            neg_q  <= 1'b0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            if (start && !busy_q) begin
                quo_q  <= dividend[W-1] ? -dividend : dividend;
                den_q  <= divisor[W-1] ? -divisor : divisor;
                neg_q  <= dividend[W-1] ^ divisor[W-1];
                rem_q  <= {W{1'b0}};
                cnt_q  <= STEPS;
                busy_q <= 1'b1;
            end else if (busy_q) begin
                quo_q <= qnext;
                rem_q <= fits ? trial[W-1:0] : {rem_q[W-2:0], quo_q[W-1]};
                cnt_q <= cnt_q - ONE;
                if (cnt_q == ONE) begin
                    busy_q <= 1'b0;
                    done_q <= 1'b1;
                    res_q  <= neg_q ? -qnext : qnext;
                end
            end
        end
    end

    assign busy     = busy_q;
    assign done     = done_q;
    assign quotient = res_q;

endmodule // aisc_div

`default_nettype wire

// >>> aisc_scaling.v
// Analog input scaling: two channels of raw converter samples are
// corrected by a signed offset, divided by a signed divisor and shown
// as signed 32-bit values through the object dictionary port.
// Assumes converter samples arrive on core_clk; the mode pins do not.
//
// Operation
// (RQ1) Two channels; each table counts two.
// (RQ2) Scaled value per channel, signed 32-bit, read-only.
// (RQ3) Offset is added before the division.
// (RQ4) Corrected reading divided; quotient becomes scaled value.
// (RQ5) Zero divisor is refused; software never writes it.
// (RQ6) Reset: offsets zero, divisors one.
// (RQ7) Voltage input: digits times 10 V over 1024.
// (RQ8) Current input: digits times 20 mA over 1024.
// (RQ9) Per-channel signed offset, readable and writable.
// (RQ10) Per-channel signed divisor, readable and writable.
// (RQ11) Truncate toward zero; recompute on each sample; code keeps only the latest of samples waiting for the divider.
`include "aisc_defines.vh"
`timescale 1ns/1ns
`default_nettype none

module aisc_scaling #(
    parameter ADC_W = 16                  // Converter sample width.
) (
    input  wire             core_clk,     // Block clock, 125 MHz.
    input  wire             rst,          // Synchronous reset, high.
    input  wire             adc_valid,    // New converter sample.
    input  wire             adc_chan,     // Sample channel, 0 is ch1.
    input  wire [ADC_W-1:0] adc_data,     // Signed raw digits.
    input  wire [1:0]       ch_current,   // Pin per channel: 1 current.
    input  wire [15:0]      od_index,     // Dictionary index.
    input  wire [7:0]       od_sub,       // Dictionary subindex.
    input  wire             od_wr,        // Write request, one cycle.
    input  wire             od_rd,        // Read request, one cycle.
    input  wire [31:0]      od_wdata,     // Write data.
    output reg              od_ack,       // Request done, one cycle.
    output reg              od_abort,     // Request refused, with ack.
    output reg  [31:0]      od_rdata,     // Read data, held.
    output reg  [31:0]      scaled_ch1,   // Scaled value, channel 1.
    output reg  [31:0]      scaled_ch2,   // Scaled value, channel 2.
    output reg  [1:0]       scaled_upd,   // Scaled value renewed.
    output reg  [31:0]      phys_ch1,     // Millivolts or microamps.
    output reg  [31:0]      phys_ch2      // Millivolts or microamps.
);

    // ============================================================
    // State of the two channels.
    reg [31:0] off_q [0:1];               // Signed offsets.
    reg [31:0] div_q [0:1];               // Signed divisors.
    reg [31:0] raw_q [0:1];               // Latest raw sample.
    reg [1:0]  pend_q;                    // Sample waits for divider.
    reg [1:0]  mode_s1_q;                 // Mode pin synchroniser.
    reg [1:0]  mode_s2_q;
    reg [1:0]  mode_s3_q;
    reg [1:0]  mode_q;                    // Settled channel modes.

    // ============================================================
    // Sample extension and physical scale.

    // Raw digits sign-extended to the width of the arithmetic.
    wire [31:0] smp_ext = {{(32-ADC_W){adc_data[ADC_W-1]}}, adc_data};

    // Full-scale figure of the channel that sends this sample.
    wire [16:0] full_scale = mode_q[adc_chan] ? `AISC_FULL_UA   // RQ8
                                              : `AISC_FULL_MV;  // RQ7

    // Digits times full scale; dropping ten bits divides by 1024.
    wire signed [48:0] phys_prod = $signed(smp_ext) *
                                   $signed({1'b0, full_scale});
    wire [31:0] phys_val = phys_prod[`AISC_SPAN_SHIFT+31:`AISC_SPAN_SHIFT];

    // ============================================================
    // Divider per channel.
    wire [1:0]  dv_busy;
    wire [1:0]  dv_done;
    wire [31:0] dv_quot [0:1];
    wire [1:0]  dv_start;
    wire [31:0] dv_num  [0:1];

    // A waiting sample starts its division as soon as the divider is
    // free; a burst of samples collapses onto the latest one.
    assign dv_start = pend_q & ~dv_busy;                        // RQ11
    // The offset is applied to the raw reading ahead of the divide.
    assign dv_num[0] = raw_q[0] + off_q[0];                     // RQ3
    assign dv_num[1] = raw_q[1] + off_q[1];                     // RQ3

    aisc_div #(
        .W        (32)
    ) u_div_ch1 (
        .core_clk (core_clk),
        .rst      (rst),
        .start    (dv_start[0]),
        .dividend (dv_num[0]),
        .divisor  (div_q[0]),
        .busy     (dv_busy[0]),
        .done     (dv_done[0]),
        .quotient (dv_quot[0])
    );

    aisc_div #(
        .W        (32)
    ) u_div_ch2 (
        .core_clk (core_clk),
        .rst      (rst),
        .start    (dv_start[1]),
        .dividend (dv_num[1]),
        .divisor  (div_q[1]),
        .busy     (dv_busy[1]),
        .done     (dv_done[1]),
        .quotient (dv_quot[1])
    );

    // ============================================================
    // Mode pins.

    // Three stages; the settled mode follows once stages two and three
    // agree, so a pin caught mid-change is not taken.
    always @(posedge core_clk) begin
        if (rst) begin
            mode_s1_q <= 2'h0;
            mode_s2_q <= 2'h0;
            mode_s3_q <= 2'h0;
            mode_q    <= 2'h0;
        end else begin
            mode_s1_q <= ch_current;
            mode_s2_q <= mode_s1_q;
            mode_s3_q <= mode_s2_q;
            if (mode_s2_q == mode_s3_q) begin
                mode_q <= mode_s3_q;
            end
        end
    end

    // ============================================================
    // Sample capture and result presentation.

    // Sample strobes of the two channels.
    wire smp_ch1 = adc_valid & ~adc_chan;
    wire smp_ch2 = adc_valid &  adc_chan;

    // A new sample sets the waiting flag even in the cycle in which
    // the divider takes the previous one, so the new sample stays waiting.
    always @(posedge core_clk) begin
        if (rst) begin
            raw_q[0] <= 32'h00000000;
            raw_q[1] <= 32'h00000000;
            pend_q   <= 2'h0;
        end else begin
            if (smp_ch1) begin
                raw_q[0]  <= smp_ext;
                pend_q[0] <= 1'b1;                              // RQ11
            end else if (dv_start[0]) begin
                pend_q[0] <= 1'b0;
            end
            if (smp_ch2) begin
                raw_q[1]  <= smp_ext;
                pend_q[1] <= 1'b1;                              // RQ11
            end else if (dv_start[1]) begin
                pend_q[1] <= 1'b0;
            end
        end
    end

    // Physical readings follow each sample of their channel at once;
    // they use the raw digits, untouched by offset and divisor.
    always @(posedge core_clk) begin
        if (rst) begin
            phys_ch1 <= 32'h00000000;
            phys_ch2 <= 32'h00000000;
        end else begin
            if (smp_ch1) begin
                phys_ch1 <= phys_val;                           // RQ7
            end
            if (smp_ch2) begin
                phys_ch2 <= phys_val;                           // RQ8
            end
        end
    end

    // The quotient is stored as the presented scaled value, and the
    // renewal pulse stands for the one cycle after each result.
    always @(posedge core_clk) begin
        if (rst) begin
            scaled_ch1 <= `AISC_SCALED_RST;
            scaled_ch2 <= `AISC_SCALED_RST;
            scaled_upd <= 2'h0;
        end else begin
            if (dv_done[0]) begin
                scaled_ch1 <= dv_quot[0];                       // RQ4
            end
            if (dv_done[1]) begin
                scaled_ch2 <= dv_quot[1];                       // RQ4
            end
            scaled_upd <= dv_done;                              // RQ2
        end
    end

    // ============================================================
    // Object dictionary port.

    // Entry decode shared by reads and writes.
    wire idx_scaled  = (od_index == `AISC_IDX_SCALED);
    wire idx_offset  = (od_index == `AISC_IDX_OFFSET);
    wire idx_divisor = (od_index == `AISC_IDX_DIVISOR);
    wire idx_any     = idx_scaled | idx_offset | idx_divisor;
    wire sub_cnt     = (od_sub == `AISC_SUB_COUNT);
    wire sub_ch      = (od_sub == `AISC_SUB_CH1) ||
                       (od_sub == `AISC_SUB_CH2);
    wire sub_ix      = (od_sub == `AISC_SUB_CH2);
    // Write data checked against the forbidden divisor value.
    wire div_ok      = (od_wdata != `AISC_DIVISOR_BAD);

    // Accepted requests; a write in the same cycle shadows a read.
    wire wr_off = od_wr && idx_offset && sub_ch;                // RQ9
    wire wr_div = od_wr && idx_divisor && sub_ch && div_ok;     // RQ5
    wire rd_cnt = od_rd && !od_wr && idx_any && sub_cnt;        // RQ1
    wire rd_ch  = od_rd && !od_wr && idx_any && sub_ch;

    // Word of the addressed channel entry, taken on a good read.
    reg [31:0] rd_word;
    always @* begin
        if (idx_scaled) begin
            rd_word = sub_ix ? scaled_ch2 : scaled_ch1;         // RQ2
        end else if (idx_offset) begin
            rd_word = off_q[sub_ix];                            // RQ9
        end else begin
            rd_word = div_q[sub_ix];                            // RQ10
        end
    end

    // Offsets and divisors start as identity scaling; refused writes
    // leave them alone.
    always @(posedge core_clk) begin
        if (rst) begin
            off_q[0] <= `AISC_OFFSET_RST;                       // RQ6
            off_q[1] <= `AISC_OFFSET_RST;                       // RQ6
            div_q[0] <= `AISC_DIVISOR_RST;                      // RQ6
            div_q[1] <= `AISC_DIVISOR_RST;                      // RQ6
        end else begin
            if (wr_off) begin
                off_q[sub_ix] <= od_wdata;                      // RQ9
            end
            if (wr_div) begin
                div_q[sub_ix] <= od_wdata;                      // RQ10
            end
        end
    end

    // Every request is answered one cycle later; writes to counts, scaled
    // values and zero divisors, and any access to unknown entries, are refused.
    always @(posedge core_clk) begin
        if (rst) begin
            od_ack   <= 1'b0;
            od_abort <= 1'b0;
            od_rdata <= 32'h00000000;
        end else begin
            od_ack   <= od_wr | od_rd;
            od_abort <= (od_wr && !wr_off && !wr_div) ||        // RQ5
                        (od_rd && !od_wr && !rd_cnt && !rd_ch);
            if (rd_cnt) begin
                od_rdata <= {24'h000000, `AISC_CHAN_COUNT};     // RQ1
            end else if (rd_ch) begin
                od_rdata <= rd_word;                            // RQ2
            end
        end
    end

endmodule // aisc_scaling

`default_nettype wire

// >>> aisc_adc_model.sv
// Converter front-end model: hands raw samples to the scaling block.
// Assumes calls start just after a rising edge of core_clk.
`timescale 1ns/1ns
`default_nettype none

module aisc_adc_model (
    output var logic        adc_valid, // Sample strobe, one cycle.
    output var logic        adc_chan,  // Sample channel.
    output var logic [15:0] adc_data,  // Raw signed digits.
    input  wire logic       core_clk   // Block clock.
);
    // ========
    // Idle lines start low before the first sample.
    initial begin
        adc_valid = 1'b0;
        adc_chan  = 1'b0;
        adc_data  = 16'h0000;
    end

    // One sample for one cycle; with rel set, valid drops and the other lines show the inverse afterwards.
    task automatic send(input logic ch, input logic [15:0] d,
                        input logic rel);
        adc_valid = 1'b1;
        adc_chan  = ch;
        adc_data  = d;
        @(posedge core_clk);
        #1;
        if (rel) begin
            adc_valid = 1'b0;
            adc_chan  = ~ch;
            adc_data  = ~d;
        end
    endtask
endmodule // aisc_adc_model

`default_nettype wire

// >>> aisc_scaling_properties.sv
// Checker of the dictionary port and the sample path of the block.
// Assumes binding to aisc_scaling with its default converter width.
`timescale 1ns/1ns
`default_nettype none

module aisc_checker (
    input wire logic        core_clk,   // Block clock.
    input wire logic        rst,        // Synchronous reset.
    input wire logic        adc_valid,  // Sample strobe.
    input wire logic        od_wr,      // Write request.
    input wire logic        od_rd,      // Read request.
    input wire logic [15:0] od_index,   // Dictionary index.
    input wire logic [7:0]  od_sub,     // Subindex.
    input wire logic [31:0] od_wdata,   // Write data.
    input wire logic        od_ack,     // Request done.
    input wire logic        od_abort,   // Request refused.
    input wire logic [31:0] od_rdata,   // Read data.
    input wire logic [31:0] scaled_ch1, // Scaled value, channel 1.
    input wire logic [1:0]  scaled_upd  // Renewal pulses.
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);

    // ========
    // Dictionary answers and refusals.
    property p_req_ack; (od_wr || od_rd) |=> od_ack; endproperty
    a_req_ack: assert property (p_req_ack)
        else $error("Request not answered next cycle.");
    property p_abort_ack; od_abort |-> od_ack; endproperty
    a_abort_ack: assert property (p_abort_ack)
        else $error("Refusal without answer.");
    property p_div_zero; od_wr && od_index == 16'h3322 &&
        od_wdata == 32'h0 |=> od_abort; endproperty
    a_div_zero: assert property (p_div_zero)
        else $error("Zero divisor accepted.");
    property p_count_ro; od_wr && od_sub == 8'h00 |=> od_abort; endproperty
    a_count_ro: assert property (p_count_ro)
        else $error("Count entry written.");
    property p_scaled_ro; od_wr && od_index == 16'h3320 |=> od_abort;
    endproperty
    a_scaled_ro: assert property (p_scaled_ro)
        else $error("Scaled value written.");
    property p_count_rd; od_rd && !od_wr && od_sub == 8'h00 &&
        od_index[15:2] == 14'h0cc8 && od_index[1:0] != 2'b11
        |=> od_rdata == 32'h2 && !od_abort; endproperty
    a_count_rd: assert property (p_count_rd)
        else $error("Count entry not two.");

    // ========
    // Scaled value of channel 1 changes only with its renewal; a renewal follows soon after a sample.
    property p_hold1; scaled_ch1 != $past(scaled_ch1) |-> scaled_upd[0];
    endproperty
    a_hold1: assert property (p_hold1)
        else $error("Scaled value changed without renewal.");
    property p_upd_late; adc_valid |-> ##[1:72] (scaled_upd != 2'b00);
    endproperty
    a_upd_late: assert property (p_upd_late)
        else $error("Sample not followed by renewal.");
endmodule // aisc_checker

bind aisc_scaling aisc_checker chk_u (
    .core_clk(core_clk), .rst(rst), .adc_valid(adc_valid),
    .od_wr(od_wr), .od_rd(od_rd), .od_index(od_index), .od_sub(od_sub),
    .od_wdata(od_wdata), .od_ack(od_ack), .od_abort(od_abort),
    .od_rdata(od_rdata), .scaled_ch1(scaled_ch1), .scaled_upd(scaled_upd)
);

`default_nettype wire

// >>> tb_top.sv
// Self-checking bench of the analog input scaling block.
// Assumes the design, its bound checker and the converter model.
`timescale 1ns/1ns
`default_nettype none

module tb_top;
    typedef struct packed {
        logic        wr;
        logic [15:0] idx;
        logic [7:0]  sub;
        logic [31:0] wd;
        logic        ab;
        logic [31:0] exp;
    } aisc_row_t;
    localparam int OFF1 = -10;
    localparam int DIV1 = -3;
    logic        core_clk, rst, od_wr, od_rd, od_ack, od_abort, adc_valid;
    logic        adc_chan;
    logic [15:0] adc_data, od_index;
    logic [7:0]  od_sub;
    logic [1:0]  ch_current, scaled_upd;
    logic [31:0] od_wdata, od_rdata, scaled_ch1, scaled_ch2;
    logic [31:0] phys_ch1, phys_ch2;
    int          mismatches = 0;
    int          comparisons = 0;
    int          cycles = 0;
    // Ordinary dictionary accesses: request beside its expected answer.
    aisc_row_t   rows [18] = '{
        '{1'b0, 16'h3320, 8'h00, 32'h0, 1'b0, 32'h2},
        '{1'b0, 16'h3320, 8'h01, 32'h0, 1'b0, 32'h0},
        '{1'b0, 16'h3321, 8'h00, 32'h0, 1'b0, 32'h2},
        '{1'b0, 16'h3321, 8'h02, 32'h0, 1'b0, 32'h0},
        '{1'b0, 16'h3322, 8'h00, 32'h0, 1'b0, 32'h2},
        '{1'b0, 16'h3322, 8'h01, 32'h0, 1'b0, 32'h1},
        '{1'b0, 16'h3322, 8'h02, 32'h0, 1'b0, 32'h1},
        '{1'b1, 16'h3320, 8'h01, 32'h5, 1'b1, 32'h0},
        '{1'b1, 16'h3322, 8'h00, 32'h3, 1'b1, 32'h0},
        '{1'b1, 16'h3322, 8'h01, 32'h0, 1'b1, 32'h0},
        '{1'b0, 16'h3322, 8'h01, 32'h0, 1'b0, 32'h1},
        '{1'b0, 16'h3324, 8'h01, 32'h0, 1'b1, 32'h0},
        '{1'b1, 16'h3321, 8'h01, 32'hfffffff6, 1'b0, 32'h0},
        '{1'b1, 16'h3322, 8'h01, 32'hfffffffd, 1'b0, 32'h0},
        '{1'b1, 16'h3321, 8'h02, 32'h7, 1'b0, 32'h0},
        '{1'b1, 16'h3322, 8'h02, 32'h4, 1'b0, 32'h0},
        '{1'b0, 16'h3321, 8'h01, 32'h0, 1'b0, 32'hfffffff6},
        '{1'b0, 16'h3322, 8'h02, 32'h0, 1'b0, 32'h4}};

    aisc_scaling dut_u (
        .core_clk(core_clk), .rst(rst), .adc_valid(adc_valid),
        .adc_chan(adc_chan), .adc_data(adc_data), .ch_current(ch_current),
        .od_index(od_index), .od_sub(od_sub), .od_wr(od_wr), .od_rd(od_rd),
        .od_wdata(od_wdata), .od_ack(od_ack), .od_abort(od_abort),
        .od_rdata(od_rdata), .scaled_ch1(scaled_ch1),
        .scaled_ch2(scaled_ch2), .scaled_upd(scaled_upd),
        .phys_ch1(phys_ch1), .phys_ch2(phys_ch2));
    aisc_adc_model adc_u (.adc_valid(adc_valid), .adc_chan(adc_chan),
        .adc_data(adc_data), .core_clk(core_clk));

    // ========
    // Shared checks, bus cycles and the closing report.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    function automatic int ph(input int r, input bit cur);
        return (r * (cur ? 20000 : 10000)) >>> 10;
    endfunction
    task automatic od_req(input aisc_row_t r);
        @(posedge core_clk);
        #1;
        od_wr = r.wr;
        od_rd = ~r.wr;
        od_index = r.idx;
        od_sub = r.sub;
        od_wdata = r.wd;
        @(posedge core_clk);
        #1;
        od_wr = 1'b0;
        od_rd = 1'b0;
        chk({31'h0, od_ack}, 32'h1);
        chk({31'h0, od_abort}, {31'h0, r.ab});
        if (!r.wr && !r.ab) chk(od_rdata, r.exp);
    endtask
    task automatic wait_upd(input int ch, input logic [31:0] exp);
        int n;
        n = 0;
        while (n < 150 && !(scaled_upd[ch] === 1'b1 &&
               (ch ? scaled_ch2 : scaled_ch1) === exp)) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        chk({31'h0, scaled_upd[ch]}, 32'h1);
        chk(ch ? scaled_ch2 : scaled_ch1, exp);
    endtask
    task automatic print_verdict();
        $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Clock and hang guard.
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            print_verdict();
        end
    end

    // ========
    // Main sequence: table, then samples, then a second reset.
    initial begin
        rst = 1'b1;
        od_wr = 1'b0;
        od_rd = 1'b0;
        od_index = 16'h0000;
        od_sub = 8'h00;
        od_wdata = 32'h0;
        ch_current = 2'b10;
        repeat (6) @(posedge core_clk);
        #1;
        rst = 1'b0;
        foreach (rows[i]) od_req(rows[i]);
        adc_u.send(1'b0, 16'h0064, 1'b1);
        @(posedge core_clk);
        #1;
        chk(phys_ch1, ph(100, 1'b0));
        wait_upd(0, (100 + OFF1) / DIV1);
        od_req(aisc_row_t'{1'b0, 16'h3320, 8'h01, 32'h0, 1'b0,
                           32'((100 + OFF1) / DIV1)});
        adc_u.send(1'b1, 16'hfff3, 1'b1);
        @(posedge core_clk);
        #1;
        chk(phys_ch2, ph(-13, 1'b1));
        wait_upd(1, (-13 + 7) / 4);
        adc_u.send(1'b0, 16'h0005, 1'b0);
        adc_u.send(1'b0, 16'h0032, 1'b1);
        wait_upd(0, (50 + OFF1) / DIV1);
        // Swap the modes: channel 1 current, channel 2 voltage.
        ch_current = 2'b01;
        repeat (5) @(posedge core_clk);
        #1;
        adc_u.send(1'b0, 16'h0200, 1'b1);
        @(posedge core_clk);
        #1;
        chk(phys_ch1, ph(512, 1'b1));
        adc_u.send(1'b1, 16'h0200, 1'b1);
        @(posedge core_clk);
        #1;
        chk(phys_ch2, ph(512, 1'b0));
        wait_upd(0, (512 + OFF1) / DIV1);
        wait_upd(1, (512 + 7) / 4);
        rst = 1'b1;
        repeat (6) @(posedge core_clk);
        #1;
        rst = 1'b0;
        chk(scaled_ch1, 32'h0);
        chk(phys_ch1, 32'h0);
        od_req(aisc_row_t'{1'b0, 16'h3321, 8'h01, 32'h0, 1'b0, 32'h0});
        od_req(aisc_row_t'{1'b0, 16'h3322, 8'h02, 32'h0, 1'b0, 32'h1});
        print_verdict();
    end
endmodule // tb_top

`default_nettype wire
